// File: hdl/vic_pkg.sv
// package: register map, field positions and types of the vector interrupt controller
package irq_ctrl_pkg;
    localparam int          NUM_SRC        = 16;
    localparam int          VEC_W          = 4;
    localparam int          ADDR_W         = 22;
    localparam logic [11:0] OFF_CONTROL    = 12'h000;
    localparam logic [11:0] OFF_STATUS     = 12'h004;
    localparam logic [11:0] OFF_FLAGS      = 12'h008;
    localparam logic [11:0] OFF_ENABLE     = 12'h00C;
    localparam logic [11:0] OFF_LEVEL      = 12'h010;
    localparam logic [11:0] OFF_BASE       = 12'h014;
    localparam logic [11:0] OFF_LOCK       = 12'h018;
    localparam logic [11:0] OFF_VECADDR    = 12'h01C;
    localparam logic [11:0] OFF_CONFIG     = 12'h020;
    localparam logic [11:0] OFF_ACK        = 12'h024;
    localparam logic [11:0] OFF_FETCH      = 12'h028;
    localparam logic [21:0] BASE_RESET     = 22'h000008;
    localparam logic [21:0] LOW_VEC_OFFSET = 22'h000010;
    localparam logic [21:0] PROG_END       = 22'h00FFFF;
    localparam logic [7:0]  KEY_FIRST      = 8'h55;
    localparam logic [7:0]  KEY_SECOND     = 8'hAA;
    localparam int          CTL_HIGH_EN    = 0;
    localparam int          CTL_LOW_EN     = 1;
    localparam int          CTL_LEVELS_EN  = 2;
    localparam int          CTL_SWI        = 3;
    localparam int          CFG_MVEC       = 0;
    localparam int          CFG_ONEWAY     = 1;
    localparam int          LOCK_BIT       = 0;
    localparam int          ISR_SHIFT      = 2;
    localparam int          LATENCY        = 3;
    localparam logic [1:0]  LAT_LAST       = 2'h2;

    typedef struct packed {
        logic              valid;
        logic              high;
        logic [VEC_W-1:0]  vec;
    } irq_pick_s;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FETCH} take_e;
endpackage : irq_ctrl_pkg

// File: hdl/vector_irq_controller.sv
// vector interrupt controller core with apb register file and vector fetch
//
// Summary of operation
// - all enabled requests merge into one core request line
// - two levels, high and low, chosen per source by level register
// - separate saved context state for high and low entries
// - pending pick by level first, then lowest vector number
// - flags set by source, cleared by software or by condition end
// - disabled source never requests
// - table base writable only while lock bit clear
// - one-shot config limits lock clear/set cycles after reset
// - multivector bit selects per-source vectors or legacy two vectors
// - table entries are 16-bit words, two locations each
// - legacy: high to base, low to base plus eight words
// - legacy without levels: everything vectors to base
// - base resets to 000008h, low vector 000018h
// - legacy core executes at vector location itself
// - multivector address is base plus twice vector; captured when taken
// - handler address is fetched entry shifted left two
// - in multivector mode level does not change vector address
// - fetch outside program memory forces system reset
// - control register holds global enables; status shows core state
// - fixed latency from request to vector output
// - lock change needs 55h then AAh with interrupts off
// - with one-shot set, unlock ignored after first lock
// - high preempts low; same level never preempts
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module vector_irq_controller
    import irq_ctrl_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                clk_en,
    input  wire logic [11:0]         paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [NUM_SRC-1:0]  src_set,
    input  wire logic [NUM_SRC-1:0]  src_auto_clr,
    input  wire logic                ext_irq,
    output logic                     core_irq,
    output logic      [ADDR_W-1:0]   vector_addr,
    output logic                     vector_high,
    output logic      [ADDR_W-1:0]   isr_addr,
    output logic                     isr_valid,
    output logic                     sys_reset_req
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] set_s1_q, set_s2_q, aclr_s1_q, aclr_s2_q;
    logic               ext_s1_q, ext_s2_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_s1_q  <= '0;
            set_s2_q  <= '0;
            aclr_s1_q <= '0;
            aclr_s2_q <= '0;
            ext_s1_q  <= 1'b0;
            ext_s2_q  <= 1'b0;
        end else if (clk_en) begin
            set_s1_q  <= src_set;
            set_s2_q  <= set_s1_q;
            aclr_s1_q <= src_auto_clr;
            aclr_s2_q <= aclr_s1_q;
            ext_s1_q  <= ext_irq;
            ext_s2_q  <= ext_s1_q;
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic wr_acc, rd_acc;
    // writes land on the edge that completes the access; reads load
    // prdata one edge earlier so that it stands while pready is high
    assign wr_acc = psel && penable && pwrite && pready && clk_en;
    assign rd_acc = psel && penable && !pwrite && !pready && clk_en;

    logic [7:0]          ctl_q;
    logic [NUM_SRC-1:0]  flag_q, en_q, lvl_q;
    logic [ADDR_W-1:0]   base_q, vecad_q;
    logic [1:0]          cfg_q;
    logic                locked_q, key1_q, key2_q, once_q;
    logic                in_high_q, in_low_q, low_saved_q;
    logic                fetch_err_q;

    // ------------------------------------------------------------
    // configuration and control
    // ------------------------------------------------------------
    // config takes a value only until a lock is set while its one-way bit is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '0;
            ctl_q <= '0;
            en_q  <= '0;
            lvl_q <= '0;
        end else if (wr_acc) begin
            if (paddr == OFF_CONTROL) ctl_q <= pwdata[7:0];
            if (paddr == OFF_CONFIG && !once_q) cfg_q <= pwdata[1:0];
            if (paddr == OFF_ENABLE) en_q <= pwdata[NUM_SRC-1:0];
            if (paddr == OFF_LEVEL) lvl_q <= pwdata[NUM_SRC-1:0];
        end
    end

    // ------------------------------------------------------------
    // base register and lock
    // ------------------------------------------------------------
    logic lock_wr, lock_ok;
    assign lock_wr = wr_acc && paddr == OFF_LOCK;
    assign lock_ok = key2_q && !ctl_q[CTL_HIGH_EN];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key1_q <= 1'b0;
            key2_q <= 1'b0;
        end else if (wr_acc) begin
            key1_q <= lock_wr && pwdata[7:0] == KEY_FIRST;
            key2_q <= lock_wr && key1_q && pwdata[7:0] == KEY_SECOND;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_q <= 1'b0;
            once_q   <= 1'b0;
        end else if (lock_wr && lock_ok && pwdata[15:8] == 8'h00) begin
            if (pwdata[LOCK_BIT]) begin
                locked_q <= 1'b1;
                if (cfg_q[CFG_ONEWAY]) once_q <= 1'b1;
            end else if (!once_q) begin
                locked_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_q <= BASE_RESET;
        end else if (wr_acc && paddr == OFF_BASE && !locked_q) begin
            base_q <= pwdata[ADDR_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // request flags
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] sw_clr, hw_set;
    assign sw_clr = (wr_acc && paddr == OFF_FLAGS) ? pwdata[NUM_SRC-1:0] : '0;
    assign hw_set = set_s2_q | {{(NUM_SRC-2){1'b0}}, ext_s2_q, ctl_q[CTL_SWI]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= '0;
        end else if (clk_en) begin
            flag_q <= (flag_q & ~sw_clr & ~aclr_s2_q) | hw_set;
        end
    end

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] pend_hi, pend_lo;
    logic               levels_en;
    irq_pick_s          pick;
    assign levels_en = ctl_q[CTL_LEVELS_EN];
    assign pend_hi = flag_q & en_q & (levels_en ? lvl_q : {NUM_SRC{1'b1}})
                     & {NUM_SRC{ctl_q[CTL_HIGH_EN]}};
    assign pend_lo = flag_q & en_q & ~lvl_q & {NUM_SRC{levels_en && ctl_q[CTL_LOW_EN]
                     && ctl_q[CTL_HIGH_EN]}};

    // level first then table order, single cycle
    always_comb begin
        pick = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend_lo[i]) begin
                pick.valid = 1'b1;
                pick.high  = 1'b0;
                pick.vec   = VEC_W'(i);
            end
        end
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend_hi[i]) begin
                pick.valid = 1'b1;
                pick.high  = 1'b1;
                pick.vec   = VEC_W'(i);
            end
        end
    end

    logic may_take;
    assign may_take = pick.valid && !in_high_q && (pick.high || !in_low_q);

    // ------------------------------------------------------------
    // vector address
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] vec_calc;
    always_comb begin
        // mode select, level ignored in multivector
        if (cfg_q[CFG_MVEC])
            vec_calc = base_q + {{(ADDR_W-VEC_W-1){1'b0}}, pick.vec, 1'b0};
        else if (levels_en && !pick.high)
            vec_calc = base_q + LOW_VEC_OFFSET;
        else
            vec_calc = base_q;
    end

    // ------------------------------------------------------------
    // take sequence
    // ------------------------------------------------------------
    take_e             st_q;
    logic [1:0]        lat_q;
    logic [ADDR_W-1:0] hold_vec_q;
    logic              hold_high_q;
    logic              ack_wr, fetch_wr, fetch_bad;
    logic [ADDR_W-1:0] isr_calc;
    assign ack_wr   = wr_acc && paddr == OFF_ACK;
    assign fetch_wr = wr_acc && paddr == OFF_FETCH && st_q == ST_FETCH;
    assign isr_calc = {pwdata[ADDR_W-ISR_SHIFT-1:0], {ISR_SHIFT{1'b0}}};
    assign fetch_bad = hold_vec_q > PROG_END || isr_calc > PROG_END;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q          <= ST_IDLE;
            lat_q         <= '0;
            hold_vec_q    <= '0;
            hold_high_q   <= 1'b0;
            vecad_q       <= '0;
            core_irq      <= 1'b0;
            vector_addr   <= '0;
            vector_high   <= 1'b0;
            isr_addr      <= '0;
            isr_valid     <= 1'b0;
            sys_reset_req <= 1'b0;
            fetch_err_q   <= 1'b0;
        end else if (clk_en) begin
            isr_valid <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (may_take) begin
                        core_irq    <= 1'b1;
                        hold_vec_q  <= vec_calc;
                        hold_high_q <= pick.high || !levels_en;
                        lat_q       <= '0;
                        st_q        <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (lat_q == LAT_LAST) begin
                        vector_addr <= hold_vec_q;
                        vector_high <= hold_high_q;
                        vecad_q     <= hold_vec_q;
                        core_irq    <= 1'b0;
                        st_q <= cfg_q[CFG_MVEC] ? ST_FETCH : ST_IDLE;
                    end else begin
                        lat_q <= lat_q + 2'h1;
                    end
                end
                ST_FETCH: begin
                    if (fetch_wr) begin
                        if (fetch_bad) begin
                            sys_reset_req <= 1'b1;
                            fetch_err_q   <= 1'b1;
                        end else begin
                            isr_addr  <= isr_calc;
                            isr_valid <= 1'b1;
                        end
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // saved context per level
    // ------------------------------------------------------------
    logic take_done;
    assign take_done = st_q == ST_WAIT && lat_q == LAT_LAST;

    // context slot per level; a high entry keeps the low one it nests over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_high_q   <= 1'b0;
            in_low_q    <= 1'b0;
            low_saved_q <= 1'b0;
        end else if (clk_en) begin
            if (take_done && hold_high_q) begin
                low_saved_q <= in_low_q;
                in_high_q   <= 1'b1;
            end else if (take_done) begin
                in_low_q <= 1'b1;
            end
            // return from handler restores saved low context
            if (ack_wr) begin
                if (in_high_q) begin
                    in_high_q <= 1'b0;
                    in_low_q  <= low_saved_q;
                end else begin
                    in_low_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    // one wait state: pready rises on the edge after the access starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && paddr > OFF_FETCH;
        end
    end

    // read data holds until the next read, so it stands with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (clk_en) begin
            if (rd_acc) begin
                case (paddr)
                    OFF_CONTROL: prdata <= {24'h000000, ctl_q};
                    OFF_STATUS:  prdata <= {26'h0, fetch_err_q, st_q != ST_IDLE,
                                            low_saved_q, in_low_q, in_high_q, core_irq};
                    OFF_FLAGS:   prdata <= {{(32-NUM_SRC){1'b0}}, flag_q};
                    OFF_ENABLE:  prdata <= {{(32-NUM_SRC){1'b0}}, en_q};
                    OFF_LEVEL:   prdata <= {{(32-NUM_SRC){1'b0}}, lvl_q};
                    OFF_BASE:    prdata <= {{(32-ADDR_W){1'b0}}, base_q};
                    OFF_LOCK:    prdata <= {30'h0, once_q, locked_q};
                    OFF_VECADDR: prdata <= {{(32-ADDR_W){1'b0}}, vecad_q};
                    OFF_CONFIG:  prdata <= {30'h0, cfg_q};
                    default:     prdata <= '0;
                endcase
            end
        end
    end
endmodule : vector_irq_controller

// File: tb/vic_chk.sv
// checker: bus answer and vector timing assertions for the interrupt controller
`timescale 1ns/1ns
module irq_ctrl_chk
    import irq_ctrl_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [11:0]       paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              core_irq,
    input wire logic [ADDR_W-1:0] vector_addr,
    input wire logic              vector_high,
    input wire logic [ADDR_W-1:0] isr_addr,
    input wire logic              isr_valid,
    input wire logic              sys_reset_req
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing one cycle after access start");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    unmapped_err_a: assert property (psel && penable && pready && paddr > OFF_FETCH |-> pslverr)
        else $error("no slave error on unmapped address");
    irq_latency_a: assert property ($rose(core_irq) |-> core_irq [*3] ##1 !core_irq)
        else $error("request to vector latency wrong");
    vector_hold_a: assert property ($changed({vector_addr, vector_high}) |-> $fell(core_irq))
        else $error("vector output moved outside vector cycle");
    vector_even_a: assert property ($fell(core_irq) |-> vector_addr[0] == 1'b0)
        else $error("odd vector address");
    isr_shift_a: assert property (isr_valid |-> isr_addr[1:0] == 2'h0 && !$past(isr_valid))
        else $error("handler address not a shifted entry");
    reset_sticky_a: assert property (sys_reset_req |=> sys_reset_req)
        else $error("system reset request dropped");
endmodule : irq_ctrl_chk

// File: tb/core_model.sv
// core model: vector table contents seen by the fetching processor
`timescale 1ns/1ns
module core_model
    import irq_ctrl_pkg::*;
(
    input  wire logic [ADDR_W-1:0] vector_addr,
    input  wire logic              bad_ptr,
    output logic      [15:0]       table_entry
);
    // table kept in flash, handlers low
    // bad_ptr points the handler past program memory on purpose
    assign table_entry = bad_ptr ? 16'hFFFF : 16'h0400 + {6'h00, vector_addr[9:0]};
endmodule : core_model

// File: tb/vector_irq_controller_tb.sv
// testbench: register, vector and lock scenarios for the interrupt controller
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module vector_irq_controller_tb;
    import irq_ctrl_pkg::*;
    logic              pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rv;
    logic [15:0]       src_set, src_auto_clr, entry;
    logic              ext_irq, core_irq, vector_high, isr_valid, sys_reset_req, bad, irq_q;
    logic [ADDR_W-1:0] vector_addr, isr_addr, isr_cap;
    int                num_errors, check_count, irq_cnt;

    vector_irq_controller uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_set(src_set),
        .src_auto_clr(src_auto_clr), .ext_irq(ext_irq), .core_irq(core_irq),
        .vector_addr(vector_addr), .vector_high(vector_high), .isr_addr(isr_addr),
        .isr_valid(isr_valid), .sys_reset_req(sys_reset_req));
    core_model core (.vector_addr(vector_addr), .bad_ptr(bad), .table_entry(entry));

    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        irq_q <= core_irq;
        if (core_irq === 1'b1 && irq_q !== 1'b1) irq_cnt <= irq_cnt + 1;
        if (isr_valid === 1'b1) isr_cap <= isr_addr;
    end

    // ----------------------------------------
    // bus and helper tasks
    // ----------------------------------------
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin @(posedge pclk); end while (pready !== 1'b1);
        rv = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(a, 1'b1, d); endtask : wr
    task automatic raise(input logic [15:0] m);
        @(posedge pclk) src_set <= m;
        repeat (2) @(posedge pclk);
        src_set <= 16'h0000;
    endtask : raise
    task automatic wait_vec(input logic [ADDR_W-1:0] ea, input logic eh);
        int n;
        n = 0;
        while (core_irq !== 1'b1 && n < 200) begin @(posedge pclk); #1; n++; end
        n = 0;
        while (core_irq === 1'b1 && n < 10) begin @(posedge pclk); #1; n++; end
        `CHK("latency", LATENCY, n)
        `CHK("vector_addr", ea, vector_addr)
        `CHK("vector_high", eh, vector_high)
    endtask : wait_vec
    task automatic done(input logic [15:0] m);
        wr(OFF_FLAGS, {16'h0000, m});
        wr(OFF_ACK, 32'h00000000);
    endtask : done
    task automatic fetch();
        logic [15:0] e;
        e = entry;
        wr(OFF_FETCH, {16'h0000, e});
        repeat (3) @(posedge pclk);
        `CHK("isr_addr", {4'h0, e, 2'h0}, isr_cap)
    endtask : fetch
    task automatic key(input logic v);
        wr(OFF_LOCK, {24'h000000, KEY_FIRST});
        wr(OFF_LOCK, {24'h000000, KEY_SECOND});
        wr(OFF_LOCK, {31'h00000000, v});
    endtask : key

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        apb(OFF_BASE, 1'b0, 32'h0);
        `CHK("base reset", {10'h000, BASE_RESET}, rv)
        apb(12'h030, 1'b0, 32'h0);
        `CHK("unmapped read", 32'h00000000, rv)
        // a source raised while clk_en is low must leave no trace
        @(posedge pclk) clk_en <= 1'b0;
        src_set <= 16'h0200;
        repeat (4) @(posedge pclk);
        src_set <= 16'h0000;
        clk_en  <= 1'b1;
        apb(OFF_FLAGS, 1'b0, 32'h0);
        `CHK("frozen flags", 32'h00000000, rv)
        $display("test reset done");
    endtask : t_reset
    task automatic t_legacy();
        wr(OFF_LEVEL, 32'h00000008);
        wr(OFF_ENABLE, 32'h00000028);
        wr(OFF_CONTROL, 32'h00000007);
        raise(16'h0008);
        wait_vec(BASE_RESET, 1'b1);
        done(16'h0008);
        raise(16'h0020);
        wait_vec(BASE_RESET + LOW_VEC_OFFSET, 1'b0);
        done(16'h0020);
        wr(OFF_CONTROL, 32'h00000001);
        raise(16'h0020);
        wait_vec(BASE_RESET, 1'b1);
        done(16'h0020);
        $display("test legacy done");
    endtask : t_legacy
    task automatic t_disabled();
        int c;
        wr(OFF_ENABLE, 32'h00000000);
        c = irq_cnt;
        raise(16'h0200);
        repeat (20) @(posedge pclk);
        `CHK("masked source", c, irq_cnt)
        wr(OFF_FLAGS, 32'h00000200);
        $display("test disabled done");
    endtask : t_disabled
    task automatic t_multi();
        wr(OFF_CONFIG, 32'h00000001);
        wr(OFF_LEVEL, 32'h00000080);
        wr(OFF_ENABLE, 32'h00000084);
        wr(OFF_CONTROL, 32'h00000007);
        raise(16'h0084);
        wait_vec(BASE_RESET + 22'h00000E, 1'b1);
        apb(OFF_VECADDR, 1'b0, 32'h0);
        `CHK("captured vector", 32'h00000016, rv)
        apb(OFF_STATUS, 1'b0, 32'h0);
        `CHK("status in high entry", 32'h00000012, rv)
        fetch();
        done(16'h0080);
        wait_vec(BASE_RESET + 22'h000004, 1'b0);
        fetch();
        done(16'h0004);
        $display("test multivector done");
    endtask : t_multi
    task automatic t_lock();
        wr(OFF_CONTROL, 32'h00000000);
        wr(OFF_BASE, 32'h00000100);
        wr(OFF_CONFIG, 32'h00000003);
        wr(OFF_CONTROL, 32'h00000001);
        key(1'b1);
        apb(OFF_LOCK, 1'b0, 32'h0);
        `CHK("lock while enabled", 1'b0, rv[0])
        wr(OFF_CONTROL, 32'h00000000);
        key(1'b1);
        apb(OFF_LOCK, 1'b0, 32'h0);
        `CHK("locked", 1'b1, rv[0])
        wr(OFF_BASE, 32'h00000200);
        apb(OFF_BASE, 1'b0, 32'h0);
        `CHK("base locked", 32'h00000100, rv)
        key(1'b0);
        apb(OFF_LOCK, 1'b0, 32'h0);
        `CHK("one-way unlock", 1'b1, rv[0])
        $display("test lock done");
    endtask : t_lock
    task automatic t_badfetch();
        wr(OFF_LEVEL, 32'h00000040);
        wr(OFF_ENABLE, 32'h00000040);
        wr(OFF_CONTROL, 32'h00000007);
        bad <= 1'b1;
        raise(16'h0040);
        wait_vec(22'h00010C, 1'b1);
        wr(OFF_FETCH, {16'h0000, entry});
        repeat (5) @(posedge pclk);
        `CHK("sys_reset_req", 1'b1, sys_reset_req)
        // second reset in mid-run: request and base return to reset values
        @(posedge pclk) presetn <= 1'b0;
        bad <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("request after reset", 1'b0, sys_reset_req)
        apb(OFF_BASE, 1'b0, 32'h0);
        `CHK("base after reset", {10'h000, BASE_RESET}, rv)
        $display("test bad fetch done");
    endtask : t_badfetch

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    initial begin
        pclk = 0; presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 12'h000; pwdata = 32'h0; src_set = 16'h0; src_auto_clr = 16'h0;
        ext_irq = 0; bad = 0; irq_q = 0; irq_cnt = 0; isr_cap = '0;
        num_errors = 0; check_count = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_legacy();
        t_disabled();
        t_multi();
        t_lock();
        t_badfetch();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        report_and_stop();
    end
endmodule : vector_irq_controller_tb

bind vector_irq_controller irq_ctrl_chk chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .core_irq(core_irq),
    .vector_addr(vector_addr), .vector_high(vector_high), .isr_addr(isr_addr),
    .isr_valid(isr_valid), .sys_reset_req(sys_reset_req));
